// [hdl/erase_suspend_resume_control.sv]
// Operation
// - Suspended: array reads open everywhere, programs refused in big block erased only for exactly 32-bit frames
// - Latency ends: clear latch, set suspend flag
// - Suspend flag shown at status bit 15
// - Resume clears the suspend flag
// - After latency accept array reads, wrap
// - After latency accept ID, security, table reads
// - After latency accept enables and page programs
// - Status reads and resets accepted immediately
// - Resume only when suspended and not busy
// - Resume: flag clears, busy within 200 ns
// - Suspend latency at most 30 us
// - Only sector and block erases suspend
module erase_suspend_resume_control
    import suspend_pkg::*;
#(
    parameter int ERASE_CYC = ERASE_CYC_DEF,
    parameter int LAT_CYC = LATENCY_CYC
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Serial link
    input wire logic csN,
    input wire logic sclk,
    input wire logic si,
    // Status flags
    output logic writeEnableLatch,
    output logic writeInProgress,
    output logic [15:0] statusWord,
    output logic eraseSuspendedFlag,
    // Accepted and refused instruction reporting
    output logic cmdAccept,
    output logic cmdReject,
    output logic [7:0] cmdCode,
    output logic arrayWrite,
    output logic [ADDR_W-1:0] arrayAddr
);
    // Erase life cycle; suspension lives inside an erase
    typedef enum {IDLE, ERASING, LATENCY, SUSPENDED, RESUMING} state_t;
    state_t state_r, state_nxt;
    // Receiver outputs
    logic opValid, frameDone;
    logic [7:0] opCode;
    logic [ADDR_W-1:0] frameAddr;
    logic [5:0] frameBits;
    logic [31:0] count_r; // Erase progress timer
    logic [31:0] latCount_r; // Suspend latency timer
    logic [7:0] bigBlock_r; // Big block under erase
    logic [7:0] curOp_r; // Opcode of current frame
    logic opOk_r; // Current frame allowed

    // Receiver
    spi_rx rx (
        .clock(clock),
        .sys_rst(sys_rst),
        .csN(csN),
        .sclk(sclk),
        .si(si),
        .opValid(opValid),
        .opCode(opCode),
        .frameDone(frameDone),
        .frameAddr(frameAddr),
        .frameBits(frameBits)
    );

    // Instruction classes
    function automatic logic isLateOp(input logic [7:0] op);
        isLateOp = op == OP_READ || op == OP_FREAD || op == OP_DOREAD
            || op == OP_QOREAD || op == OP_DIOREAD || op == OP_QIOREAD
            || op == OP_QWREAD || op == OP_WRAP
            || op == OP_MDID || op == OP_MDID2 || op == OP_MDID4
            || op == OP_JEDID || op == OP_UNIQ || op == OP_WAKE
            || op == OP_SECRD || op == OP_PTAB
            || op == OP_WREN || op == OP_WRDI || op == OP_PP
            || op == OP_QPP || op == OP_RESUME;
    endfunction
    function automatic logic isAnyTimeOp(input logic [7:0] op);
        isAnyTimeOp = op == OP_RDSR1 || op == OP_RDSR2 || op == OP_RDSR3
            || op == OP_RSTEN || op == OP_RST;
    endfunction

    // Shape and target of the frame now ending
    wire isErase = curOp_r == OP_SE || curOp_r == OP_BE32 || curOp_r == OP_BE64;
    wire isProg = curOp_r == OP_PP || curOp_r == OP_QPP;
    // Exact bit counts; a short frame executes nothing, while a program frame longer than 32 bits still executes
    wire addrFrame = frameBits == 6'h20;
    wire opFrame = frameBits == 6'h08;
    // Address lands in the 64 KB block held by the erase
    wire inBig = frameAddr[ADDR_W-1:BIG_LSB] == bigBlock_r;
    // Early arrival of a late op is refused
    wire earlyOk = isAnyTimeOp(opCode);
    wire suspOk = isAnyTimeOp(opCode) || isLateOp(opCode);
    // Gate chosen by the state at the opcode byte
    wire gateOk = (state_r == SUSPENDED) ? suspOk
                : (state_r == LATENCY) ? earlyOk : 1'b1;
    // Program in big block refused while suspended, if its frame is exactly 32 bits
    wire progHit = state_r == SUSPENDED && isProg && addrFrame && inBig;
    // Latch commands act only as bare opcodes
    wire doWren = frameDone && opOk_r && opFrame && curOp_r == OP_WREN;
    wire doWrdi = frameDone && opOk_r && opFrame && curOp_r == OP_WRDI;
    // Only sector and block erases start a suspendable erase
    wire doErase = frameDone && state_r == IDLE && isErase && addrFrame
        && writeEnableLatch;
    wire doSuspend = frameDone && state_r == ERASING && opFrame && curOp_r == OP_SUSPEND;
    // Resume only with suspend flag set and not busy
    wire doResume = frameDone && opOk_r && opFrame && curOp_r == OP_RESUME
        && eraseSuspendedFlag && !writeInProgress;
    // Program outside the held block needs the latch and a full address
    wire doProg = frameDone && opOk_r && isProg && state_r == SUSPENDED
        && frameBits >= 6'h20 && writeEnableLatch && !progHit;
    // Resume that finds no suspended erase is dropped and reported so
    wire resumeMiss = curOp_r == OP_RESUME
        && !(opFrame && eraseSuspendedFlag && !writeInProgress);
    // Suspend with no erase to interrupt is dropped as well
    wire suspMiss = curOp_r == OP_SUSPEND && !(opFrame && state_r == ERASING);
    // Frames that pass the gate yet do nothing
    wire dropped = progHit || resumeMiss || suspMiss;
    // Own timer, so the latency does not depend on erase progress
    wire latDone = state_r == LATENCY && latCount_r >= LAT_CYC - 1;

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            // Erase starts only with the latch set
            IDLE: if (doErase) state_nxt = ERASING;
            // Erase ends on its own unless suspended first
            ERASING: begin
                if (doSuspend) state_nxt = LATENCY;
                else if (count_r >= ERASE_CYC - 1) state_nxt = IDLE;
            end
            // Only status reads and resets pass meanwhile
            LATENCY: if (latDone) state_nxt = SUSPENDED;
            // Array open outside the held block
            SUSPENDED: if (doResume) state_nxt = RESUMING;
            RESUMING: state_nxt = ERASING;
            default: state_nxt = IDLE;
        endcase
    end

    // State and timers; erase progress kept across suspend
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= IDLE;
            count_r <= 32'h0;
            latCount_r <= 32'h0;
            bigBlock_r <= 8'h0;
        end else begin
            state_r <= state_nxt;
            if (doErase) begin
                count_r <= 32'h0;
                bigBlock_r <= frameAddr[ADDR_W-1:BIG_LSB];
            end else if (state_r == ERASING && !doSuspend) begin
                count_r <= count_r + 32'h1;
            end
            // Restarts at every suspend; erase count left untouched
            latCount_r <= (state_r == LATENCY && !latDone) ? latCount_r + 32'h1 : 32'h0;
        end
    end

    // Frame gating captured at the opcode byte
    // Verdict held until the next opcode byte arrives
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            curOp_r <= 8'h0;
            opOk_r <= 1'b0;
        end else if (opValid) begin
            curOp_r <= opCode;
            opOk_r <= gateOk;
        end
    end

    // Status flags
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            writeEnableLatch <= 1'b0;
            writeInProgress <= 1'b0;
            eraseSuspendedFlag <= 1'b0;
        end else begin
            // Clears win over a same-cycle write enable
            if (latDone || doErase || doProg || doWrdi) begin
                writeEnableLatch <= 1'b0;
            end else if (doWren) begin
                writeEnableLatch <= 1'b1;
            end
            // Suspend flag set the cycle the latency ends
            if (latDone) begin
                eraseSuspendedFlag <= 1'b1;
            end else if (doResume) begin
                eraseSuspendedFlag <= 1'b0;
            end
            // Busy again one cycle after resume, well inside 200 ns
            writeInProgress <= state_nxt == ERASING || state_nxt == RESUMING
                || state_nxt == LATENCY;
        end
    end

    // Reporting outputs
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cmdAccept <= 1'b0;
            cmdReject <= 1'b0;
            cmdCode <= 8'h0;
            arrayWrite <= 1'b0;
            arrayAddr <= '0;
        end else begin
            // Passed the gate and not dropped
            cmdAccept <= frameDone && opOk_r && !dropped;
            // Refused by the gate, or passed it and dropped
            cmdReject <= frameDone && (!opOk_r || dropped);
            cmdCode <= frameDone ? curOp_r : cmdCode;
            // One pulse per program executed during suspension
            arrayWrite <= doProg;
            arrayAddr <= frameDone ? frameAddr : arrayAddr;
        end
    end

    // Status word: suspend at bit 15, latch bit 1, busy bit 0
    assign statusWord = {eraseSuspendedFlag, 13'h0, writeEnableLatch, writeInProgress};
endmodule

// [hdl/spi_rx.sv]
// Serial receiver: sampled link clock, frame with opcode and address
module spi_rx
    import suspend_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Link pins
    input wire logic csN,
    input wire logic sclk,
    input wire logic si,
    // Decoded frame
    output logic opValid,
    output logic [7:0] opCode,
    output logic frameDone,
    output logic [ADDR_W-1:0] frameAddr,
    output logic [5:0] frameBits
);
    // Two-stage synchronisers; stage one feeds only stage two
    logic [1:0] csSync_r, sclkSync_r, siSync_r;
    logic sclkPrev_r, csPrev_r;
    logic [31:0] shift_r;
    logic [5:0] count_r;
    wire csLow = ~csSync_r[1];
    wire rise = sclkSync_r[1] & ~sclkPrev_r & csLow;
    wire [31:0] shiftNxt = {shift_r[30:0], siSync_r[1]};

    // Synchronise pins
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            csSync_r <= 2'h3;
            sclkSync_r <= 2'h3;
            siSync_r <= 2'h0;
        end else begin
            csSync_r <= {csSync_r[0], csN};
            sclkSync_r <= {sclkSync_r[0], sclk};
            siSync_r <= {siSync_r[0], si};
        end
    end

    // Shift bits on rising link edges, restart on chip select high
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sclkPrev_r <= 1'b1;
            csPrev_r <= 1'b1;
            shift_r <= 32'h0;
            count_r <= 6'h0;
        end else begin
            sclkPrev_r <= sclkSync_r[1];
            csPrev_r <= csLow;
            if (!csLow) begin
                count_r <= 6'h0;
            end else if (rise) begin
                shift_r <= shiftNxt;
                count_r <= (count_r == 6'h3F) ? count_r : count_r + 6'h1;
            end
        end
    end

    // Outputs from flops
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            opValid <= 1'b0;
            opCode <= 8'h0;
            frameDone <= 1'b0;
            frameAddr <= '0;
            frameBits <= 6'h0;
        end else begin
            opValid <= rise && count_r == 6'h7;
            if (rise && count_r == 6'h7) begin
                opCode <= shiftNxt[7:0];
            end
            // Frame end: chip select just rose
            frameDone <= ~csLow & csPrev_r;
            if (~csLow & csPrev_r) begin
                frameAddr <= shift_r[ADDR_W-1:0];
                frameBits <= count_r;
            end
        end
    end
endmodule

// [hdl/suspend_pkg.sv]
package suspend_pkg;
    // Instruction codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FREAD = 8'h0B;
    localparam logic [7:0] OP_DOREAD = 8'h3B;
    localparam logic [7:0] OP_QOREAD = 8'h6B;
    localparam logic [7:0] OP_DIOREAD = 8'hBB;
    localparam logic [7:0] OP_QIOREAD = 8'hEB;
    localparam logic [7:0] OP_QWREAD = 8'hE7;
    localparam logic [7:0] OP_WRAP = 8'h77;
    localparam logic [7:0] OP_MDID = 8'h90;
    localparam logic [7:0] OP_MDID2 = 8'h92;
    localparam logic [7:0] OP_MDID4 = 8'h94;
    localparam logic [7:0] OP_JEDID = 8'h9F;
    localparam logic [7:0] OP_UNIQ = 8'h4B;
    localparam logic [7:0] OP_WAKE = 8'hAB;
    localparam logic [7:0] OP_SECRD = 8'h48;
    localparam logic [7:0] OP_PTAB = 8'h5A;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_QPP = 8'h32;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_RDSR3 = 8'h15;
    localparam logic [7:0] OP_RSTEN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hD8;
    // Status bit position of the suspend flag
    localparam int SUSPEND_BIT = 15;
    // Address field: 64 KB big block index bits
    localparam int ADDR_W = 24;
    localparam int BIG_LSB = 16;
    // Timing
    localparam int CLK_NS = 25;
    localparam int LATENCY_US = 30;
    localparam int LATENCY_CYC = (LATENCY_US * 1000) / CLK_NS;
    localparam int RESUME_NS = 200;
    localparam int RESUME_CYC = RESUME_NS / CLK_NS;
    localparam int ERASE_CYC_DEF = 8000;
endpackage

// [tb/spi_host_model.sv]
// Host controller: sends whole frames, link clock parked low between them
module spi_host_model (
    // Bench clock pacing the link
    input wire logic clock,
    // Link pins toward the device
    output logic csN,
    output logic sclk,
    output logic si
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle deselected
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // 8 or 32 bits MSB first, 200 ns link period; resume is sent this way too
    task automatic frame(input logic [31:0] word, input logic wide);
        int n;
        n = wide ? 32 : 8;
        @(negedge clock);
        csN = 1'b0;
        repeat (4) @(negedge clock);
        for (int k = 0; k < n; k++) begin
            si = word[31 - k];
            repeat (4) @(negedge clock);
            sclk = 1'b1;
            repeat (4) @(negedge clock);
            sclk = 1'b0;
        end
        // Released line must not keep the last bit
        si = ~si;
        repeat (2) @(negedge clock);
        csN = 1'b1;
        repeat (4) @(negedge clock);
    endtask
endmodule

// [tb/suspend_assertions.sv]
// Watches suspend and resume flags against the instructions reported taken
module suspend_checker
    import suspend_pkg::*;
#(
    parameter int ERASE_CYC = ERASE_CYC_DEF,
    parameter int LAT_CYC = LATENCY_CYC
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Flags
    input wire logic writeEnableLatch,
    input wire logic writeInProgress,
    input wire logic [15:0] statusWord,
    input wire logic eraseSuspendedFlag,
    // Instruction reports
    input wire logic cmdAccept,
    input wire logic cmdReject,
    input wire logic [7:0] cmdCode,
    input wire logic arrayWrite
);
    timeunit 1ns;
    timeprecision 1ps;
    // Slack covers the frame-end synchroniser
    localparam int LAT_MAX = LAT_CYC + 8;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Cycles from a reported suspend until the suspended state shows
    int latWait;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            latWait <= 0;
        end else if (cmdAccept && cmdCode == OP_SUSPEND) begin
            latWait <= 1;
        end else if (latWait != 0 && !eraseSuspendedFlag && writeInProgress) begin
            latWait <= latWait + 1;
        end else begin
            latWait <= 0;
        end
    end
    // Suspend and resume as the device reports them taken
    sequence s_susp_taken;
        cmdAccept && cmdCode == OP_SUSPEND;
    endsequence
    sequence s_resume_taken;
        cmdAccept && cmdCode == OP_RESUME;
    endsequence
    a_single_verdict: assert property (!(cmdAccept && cmdReject))
        else $error("accept and reject in one cycle");
    a_status_suspend: assert property (statusWord[SUSPEND_BIT] == eraseSuspendedFlag)
        else $error("status bit 15 differs from suspend flag");
    a_status_low: assert property (statusWord[1:0] == {writeEnableLatch, writeInProgress})
        else $error("status latch or busy bit differs");
    a_latch_cleared: assert property ($rose(eraseSuspendedFlag) |-> !writeEnableLatch)
        else $error("latch still set when suspended");
    a_susp_erase: assert property ($rose(eraseSuspendedFlag) |-> $past(writeInProgress))
        else $error("suspended without an erase running");
    a_susp_latency: assert property (latWait <= LAT_MAX)
        else $error("suspend latency too long");
    a_latency_busy: assert property (s_susp_taken |-> writeInProgress && !eraseSuspendedFlag)
        else $error("suspend flag set before latency ended");
    a_resume_guard: assert property ($fell(eraseSuspendedFlag) |-> !$past(writeInProgress))
        else $error("resume taken while busy");
    a_resume_busy: assert property (s_resume_taken |->
        ##[0:8] (!eraseSuspendedFlag && writeInProgress))
        else $error("resume did not restart erase in time");
    a_write_suspended: assert property (arrayWrite |-> eraseSuspendedFlag)
        else $error("array write outside suspension");
endmodule

bind erase_suspend_resume_control suspend_checker #(
    .ERASE_CYC(ERASE_CYC),
    .LAT_CYC(LAT_CYC)
) chk (
    .clock(clock),
    .sys_rst(sys_rst),
    .writeEnableLatch(writeEnableLatch),
    .writeInProgress(writeInProgress),
    .statusWord(statusWord),
    .eraseSuspendedFlag(eraseSuspendedFlag),
    .cmdAccept(cmdAccept),
    .cmdReject(cmdReject),
    .cmdCode(cmdCode),
    .arrayWrite(arrayWrite)
);

// [tb/testbench.sv]
module testbench
    import suspend_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Shortened counts keep the run brief
    localparam int LAT = 600;
    localparam int ERASE = 2000;
    localparam logic [23:0] ERASE_ADDR = 24'h012000;
    localparam logic [23:0] SAFE_ADDR = 24'h020000;
    logic clock = 1'b0;
    logic sysRst = 1'b1;
    logic csN, sclk, si, write_enable_latch, write_in_progress, susp, acc, rej, aw;
    logic [15:0] status;
    logic [7:0] code;
    logic [23:0] addr;
    logic accSeen, rejSeen, wrSeen;
    int nFail = 0;
    int nCompared = 0;
    initial forever #12.5 clock = ~clock;
    spi_host_model host (.clock(clock), .csN(csN), .sclk(sclk), .si(si));
    erase_suspend_resume_control #(.ERASE_CYC(ERASE), .LAT_CYC(LAT)) DUT (
        .clock(clock), .sys_rst(sysRst), .csN(csN), .sclk(sclk), .si(si),
        .writeEnableLatch(write_enable_latch), .writeInProgress(write_in_progress), .statusWord(status),
        .eraseSuspendedFlag(susp), .cmdAccept(acc), .cmdReject(rej),
        .cmdCode(code), .arrayWrite(aw), .arrayAddr(addr));
    // Catch one-cycle pulses
    always @(posedge clock) begin
        if (acc === 1'b1) accSeen <= 1'b1;
        if (rej === 1'b1) rejSeen <= 1'b1;
        if (aw === 1'b1) wrSeen <= 1'b1;
    end
    task automatic stopTest;
        $display("Compared %0d, failed %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        nCompared++;
        if (ok !== 1'b1) begin
            nFail++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    // Bounded wait on busy or suspend flag; a hang ends the run
    task automatic waitOn(input logic onBusy, input logic level, input int limit);
        int n;
        n = 0;
        while ((onBusy ? write_in_progress : susp) !== level && n < limit) begin
            @(negedge clock);
            n++;
        end
        check(n < limit, "flag wait ran out");
        if (n == limit) stopTest();
    endtask
    // One frame, then the verdict pulse must match
    task automatic issue(input logic [31:0] word, input logic wide, input logic expAcc);
        accSeen = 1'b0;
        rejSeen = 1'b0;
        wrSeen = 1'b0;
        host.frame(word, wide);
        repeat (8) @(negedge clock);
        check(accSeen === expAcc && rejSeen === !expAcc, $sformatf("verdict op %h", word[31:24]));
        check(code === word[31:24], "reported opcode differs");
    endtask
    task automatic startSuspend(input logic [7:0] eraseOp);
        issue({OP_WREN, 24'h0}, 1'b0, 1'b1);
        issue({eraseOp, ERASE_ADDR}, 1'b1, 1'b1);
        check(write_in_progress === 1'b1, "erase not busy");
        // Latch set again during the erase so that the latency must clear it
        issue({OP_WREN, 24'h0}, 1'b0, 1'b1);
        issue({OP_SUSPEND, 24'h0}, 1'b0, 1'b1);
    endtask
    task automatic latencyPhase;
        issue({OP_RDSR1, 24'h0}, 1'b0, 1'b1);
        issue({OP_READ, SAFE_ADDR}, 1'b1, 1'b0);
        check(susp === 1'b0 && write_in_progress === 1'b1 && write_enable_latch === 1'b1, "flag set early");
        waitOn(1'b0, 1'b1, LAT);
        check(write_enable_latch === 1'b0 && write_in_progress === 1'b0 && status[SUSPEND_BIT] === 1'b1, "state");
    endtask
    task automatic suspendedOps;
        logic [7:0] ops [20] = '{OP_READ, OP_FREAD, OP_DOREAD, OP_QOREAD, OP_DIOREAD,
            OP_QIOREAD, OP_QWREAD, OP_WRAP, OP_MDID, OP_MDID2, OP_MDID4, OP_JEDID, OP_UNIQ,
            OP_WAKE, OP_SECRD, OP_PTAB, OP_RDSR2, OP_RDSR3, OP_WREN, OP_WRDI};
        foreach (ops[i]) issue({ops[i], SAFE_ADDR}, 1'b1, 1'b1);
        issue({OP_SE, SAFE_ADDR}, 1'b1, 1'b0);
        issue({OP_WREN, 24'h0}, 1'b0, 1'b1);
        issue({OP_PP, 24'h01FFFF}, 1'b1, 1'b0);
        check(wrSeen === 1'b0, "write into erased block");
        issue({OP_WREN, 24'h0}, 1'b0, 1'b1);
        issue({OP_QPP, SAFE_ADDR}, 1'b1, 1'b1);
        check(wrSeen === 1'b1 && addr === SAFE_ADDR, "program next block");
        issue({OP_WREN, 24'h0}, 1'b0, 1'b1);
        issue({OP_PP, SAFE_ADDR}, 1'b1, 1'b1);
    endtask
    task automatic resumeErase;
        issue({OP_RESUME, 24'h0}, 1'b0, 1'b1);
        check(susp === 1'b0 && write_in_progress === 1'b1, "resume state");
        issue({OP_RESUME, 24'h0}, 1'b0, 1'b0);
        waitOn(1'b1, 1'b0, ERASE);
        issue({OP_RESUME, 24'h0}, 1'b0, 1'b0);
    endtask
    initial begin
        repeat (10) @(negedge clock);
        check(status === 16'h0000 && {write_enable_latch, write_in_progress, susp, acc, rej, aw} === 6'b0, "reset");
        sysRst = 1'b0;
        repeat (3) @(negedge clock);
        startSuspend(OP_SE);
        latencyPhase();
        suspendedOps();
        resumeErase();
        // Reset pair needs no latency
        startSuspend(OP_BE64);
        issue({OP_RSTEN, 24'h0}, 1'b0, 1'b1);
        issue({OP_RST, 24'h0}, 1'b0, 1'b1);
        stopTest();
    end
endmodule
